// ===== include/adc_mode_regs.svh
`ifndef ADC_MODE_REGS_SVH
`define ADC_MODE_REGS_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define MODE_CTRL_OFS        12'h000
`define MODE_STATUS_OFS      12'h004
`define MODE_RESULT_OFS      12'h008
`define MODE_LSB_OFS         12'h00C

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CTRL_RESULT_LOAD_BIT 0
`define CTRL_SHDN_LVL_BIT    1
`define ST_REF_INT_BIT       0
`define ST_REF_OE_BIT        1
`define ST_RANGE_WIDE_BIT    2
`define ST_PD_BIT            3
`define ST_SHDN_BIT          4
`define ST_IFACE_LSB         5
`define ST_SETTLING_BIT      7

// ----------------------------------------------------------------
// Reset values and coding
// ----------------------------------------------------------------
`define CTRL_RESET           32'h0000_0000
`define CODE_WIDTH           16
`define CODE_STEPS           65536
// Full-scale spans in microvolts
`define FSR_WIDE_UV          32'h0131_2D00
`define FSR_NARROW_UV        32'h0098_9680

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_MHZ              200
`define RANGE_SETTLE_US      80
`define RANGE_SETTLE_CYC     (`RANGE_SETTLE_US * `CLK_MHZ)

`endif

// ===== include/adc_mode_pkg.sv
package adc_mode_pkg;

  // Interface mode decoded from the two select pins
  typedef enum logic [1:0] {
    IFACE_PARALLEL = 2'h0,
    IFACE_SERIAL   = 2'h1,
    IFACE_BYTE     = 2'h3
  } iface_mode_t;

  // Power state, Gray coded along run -> standby -> shutdown
  typedef enum logic [1:0] {
    PWR_RUN      = 2'h0,
    PWR_STANDBY  = 2'h1,
    PWR_SHUTDOWN = 2'h3
  } pwr_state_t;

endpackage : adc_mode_pkg

// ===== design/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none

// Two-flop synchroniser for a bundle of pin levels
module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             core_clk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] pin_in,
  output var  logic [WIDTH-1:0] pin_sync_out
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] sync_nxt;

  // ----------------------------------------------------------------
  // Next values: first stage read only by the second
  // ----------------------------------------------------------------
  always_comb begin
    meta_nxt = pin_in;
    sync_nxt = meta_r;
  end

  // Registers; reset value is a constant only
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      meta_r       <= '0;
      pin_sync_out <= '0;
    end else begin
      meta_r       <= meta_nxt;
      pin_sync_out <= sync_nxt;
    end
  end

endmodule : pin_sync

`default_nettype wire

// ===== design/adc_mode_pin_control.sv
// How it works
// - Results are 16-bit twos complement words
// - One step is span over 65536
// - Select high enables internal band-gap reference
// - Select low powers band-gap down, pin input
// - Reference buffer stays enabled in every mode but shutdown
// - Reference select follows pin level, also at start
// - Range high wide, low narrow, all channels
// - Range pin change reconfigures channels at once
// - Request low enters standby or shutdown by range
// - Shutdown powers everything down; standby keeps reference, regulators
// - Power-down accepted anytime; host waits recovery
// - Two selects decode parallel, serial, byte modes
`timescale 1ns/1ps
`default_nettype none
`include "adc_mode_regs.svh"

module adc_mode_pin_control #(
  parameter logic SHDN_RANGE_LEVEL = 1'b0,
  parameter int   SETTLE_CYCLES    = `RANGE_SETTLE_CYC
) (
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  input  wire logic        reference_source_select,
  input  wire logic        range_select,
  input  wire logic        power_down_request_n,
  input  wire logic        interface_select_primary,
  input  wire logic        interface_select_secondary,
  input  wire logic [15:0] conv_result,
  input  wire logic        conv_result_valid,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  output var  logic        bandgap_enable,
  output var  logic        reference_io_pin_oe_n,
  output var  logic        reference_buffer_enable,
  output var  logic        range_wide,
  output var  logic        analog_power_enable,
  output var  logic        regulator_enable,
  output var  logic [1:0]  interface_mode,
  output var  logic        range_settling
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Pins are asynchronous: two flops trade two cycles of lag for safety
  logic [4:0] pins_s;

  pin_sync #(
    .WIDTH(5)
  ) u_pin_sync (
    .core_clk     (core_clk),
    .reset_n      (reset_n),
    .pin_in       ({interface_select_secondary, interface_select_primary,
                    power_down_request_n, range_select, reference_source_select}),
    .pin_sync_out (pins_s)
  );

  logic ref_int_s;
  logic range_s;
  logic pd_n_s;
  logic sel_pri_s;
  logic sel_sec_s;

  // Named taps of the synchronised bundle
  assign ref_int_s = pins_s[0];
  assign range_s   = pins_s[1];
  assign pd_n_s    = pins_s[2];
  assign sel_pri_s = pins_s[3];
  assign sel_sec_s = pins_s[4];

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Interface decode from the primary and secondary selects
  function automatic adc_mode_pkg::iface_mode_t decode_iface(input logic pri,
                                                             input logic sec);
    if (!pri) begin
      decode_iface = adc_mode_pkg::IFACE_PARALLEL;
    end else if (!sec) begin
      decode_iface = adc_mode_pkg::IFACE_SERIAL;
    end else begin
      decode_iface = adc_mode_pkg::IFACE_BYTE;
    end
  endfunction : decode_iface

  // Step size in microvolts, truncated: span / 65536
  // Fractions of a microvolt are dropped; software scales further
  function automatic logic [31:0] lsb_uv(input logic wide);
    lsb_uv = (wide ? `FSR_WIDE_UV : `FSR_NARROW_UV) / `CODE_STEPS;
  endfunction : lsb_uv

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  adc_mode_pkg::pwr_state_t pwr_r;
  adc_mode_pkg::pwr_state_t pwr_nxt;
  logic        bandgap_nxt;
  logic        ref_oe_n_nxt;
  logic        ref_buf_nxt;
  logic        range_wide_nxt;
  logic        analog_nxt;
  logic        regulator_nxt;
  logic [1:0]  iface_nxt;
  logic        range_prev_r;
  logic        range_prev_nxt;
  logic [14:0] settle_cnt_r;
  logic [14:0] settle_cnt_nxt;
  logic        settling_nxt;
  logic [15:0] result_r;
  logic [15:0] result_nxt;
  logic        result_load_r;
  logic        result_load_nxt;
  logic [31:0] prdata_nxt;
  logic        pready_nxt;
  logic        pslverr_nxt;

  logic        setup_ph;
  logic        wr_ctrl;
  assign setup_ph = psel && !penable;
  assign wr_ctrl  = psel && penable && pready && pwrite && (paddr == `MODE_CTRL_OFS);

  // ----------------------------------------------------------------
  // Power state: request low picks standby or shutdown by range
  // ----------------------------------------------------------------
  // Run wins whenever the request is high, whatever the range level
  always_comb begin
    if (pd_n_s) begin
      pwr_nxt = adc_mode_pkg::PWR_RUN;
    end else if (range_s == SHDN_RANGE_LEVEL) begin
      pwr_nxt = adc_mode_pkg::PWR_SHUTDOWN;
    end else begin
      pwr_nxt = adc_mode_pkg::PWR_STANDBY;
    end
  end

  // ----------------------------------------------------------------
  // Analog control outputs
  // ----------------------------------------------------------------
  always_comb begin
    case (pwr_nxt)
      adc_mode_pkg::PWR_SHUTDOWN: begin
        analog_nxt    = 1'b0;
        regulator_nxt = 1'b0;
        bandgap_nxt   = 1'b0;
      end
      adc_mode_pkg::PWR_STANDBY: begin
        analog_nxt    = 1'b0;
        regulator_nxt = 1'b1;
        bandgap_nxt   = ref_int_s;
      end
      default: begin
        analog_nxt    = 1'b1;
        regulator_nxt = 1'b1;
        bandgap_nxt   = ref_int_s;
      end
    endcase
    // Pin driven only in internal mode; high impedance input otherwise
    ref_oe_n_nxt   = !bandgap_nxt;
    // Buffer serves both reference sources; only shutdown stops it
    ref_buf_nxt    = (pwr_nxt != adc_mode_pkg::PWR_SHUTDOWN);
    range_wide_nxt = range_s;
    iface_nxt      = decode_iface(sel_pri_s, sel_sec_s);
  end

  // ----------------------------------------------------------------
  // Range settle flag: host must hold off conversions meanwhile
  // ----------------------------------------------------------------
  // 15-bit counter covers the 80 us hold; larger counts would be cut
  always_comb begin
    range_prev_nxt = range_s;
    if (range_s != range_prev_r) begin
      settle_cnt_nxt = 15'(SETTLE_CYCLES);
    end else if (settle_cnt_r != 15'h0000) begin
      settle_cnt_nxt = settle_cnt_r - 15'h0001;
    end else begin
      settle_cnt_nxt = settle_cnt_r;
    end
    settling_nxt = (settle_cnt_nxt != 15'h0000);
  end

  // ----------------------------------------------------------------
  // Result capture, armed by software through the control word
  // ----------------------------------------------------------------
  always_comb begin
    result_load_nxt = result_load_r;
    if (wr_ctrl) begin
      result_load_nxt = pwdata[`CTRL_RESULT_LOAD_BIT];
    end
    // Raw code kept as is: already twos complement
    result_nxt = result_r;
    if (conv_result_valid && result_load_r) begin
      result_nxt = conv_result;
    end
  end

  // Capture disarmed after reset so no stale code lands unasked
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      result_r      <= 16'h0000;
      result_load_r <= 1'(`CTRL_RESET);
    end else begin
      result_r      <= result_nxt;
      result_load_r <= result_load_nxt;
    end
  end

  // ----------------------------------------------------------------
  // APB slave, no wait states
  // ----------------------------------------------------------------
  // Read word built in setup, so the access cycle shows only flops
  always_comb begin
    pready_nxt  = setup_ph;
    pslverr_nxt = 1'b0;
    prdata_nxt  = 32'h0000_0000;
    if (setup_ph) begin
      if (paddr == `MODE_CTRL_OFS) begin
        prdata_nxt[`CTRL_RESULT_LOAD_BIT] = result_load_r;
        prdata_nxt[`CTRL_SHDN_LVL_BIT]    = SHDN_RANGE_LEVEL;
      end else if (paddr == `MODE_STATUS_OFS) begin
        prdata_nxt[`ST_REF_INT_BIT]    = bandgap_enable;
        prdata_nxt[`ST_REF_OE_BIT]     = !reference_io_pin_oe_n;
        prdata_nxt[`ST_RANGE_WIDE_BIT] = range_wide;
        prdata_nxt[`ST_PD_BIT]         = (pwr_r != adc_mode_pkg::PWR_RUN);
        prdata_nxt[`ST_SHDN_BIT]       = (pwr_r == adc_mode_pkg::PWR_SHUTDOWN);
        prdata_nxt[`ST_IFACE_LSB +: 2] = interface_mode;
        prdata_nxt[`ST_SETTLING_BIT]   = range_settling;
      end else if (paddr == `MODE_RESULT_OFS) begin
        // Sign-extended so software reads a signed word
        prdata_nxt = {{16{result_r[15]}}, result_r};
      end else if (paddr == `MODE_LSB_OFS) begin
        prdata_nxt = lsb_uv(range_wide);
      end else begin
        pslverr_nxt = 1'b1;
      end
    end
  end

  // Answer stands for the access cycle only
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata  <= prdata_nxt;
      pready  <= pready_nxt;
      pslverr <= pslverr_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Registers of the pin paths
  // ----------------------------------------------------------------
  // Reset parks power off with the reference pin as an input
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      pwr_r                   <= adc_mode_pkg::PWR_RUN;
      bandgap_enable          <= 1'b0;
      reference_io_pin_oe_n   <= 1'b1;
      reference_buffer_enable <= 1'b0;
      range_wide              <= 1'b0;
      analog_power_enable     <= 1'b0;
      regulator_enable        <= 1'b0;
      interface_mode          <= 2'h0;
    end else begin
      pwr_r                   <= pwr_nxt;
      bandgap_enable          <= bandgap_nxt;
      reference_io_pin_oe_n   <= ref_oe_n_nxt;
      reference_buffer_enable <= ref_buf_nxt;
      range_wide              <= range_wide_nxt;
      analog_power_enable     <= analog_nxt;
      regulator_enable        <= regulator_nxt;
      interface_mode          <= iface_nxt;
    end
  end

  // Settle counter and its flag
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      range_prev_r   <= 1'b0;
      settle_cnt_r   <= 15'h0000;
      range_settling <= 1'b0;
    end else begin
      range_prev_r   <= range_prev_nxt;
      settle_cnt_r   <= settle_cnt_nxt;
      range_settling <= settling_nxt;
    end
  end

endmodule : adc_mode_pin_control

`default_nettype wire

// ===== verification/adc_mode_pin_control_properties.sv
`timescale 1ns/1ps
`default_nettype none
module adc_mode_pin_control_checker #(
  parameter logic SHDN_RANGE_LEVEL = 1'b0
) (
  input wire logic       core_clk,
  input wire logic       reset_n,
  input wire logic       reference_source_select,
  input wire logic       range_select,
  input wire logic       power_down_request_n,
  input wire logic       interface_select_primary,
  input wire logic       interface_select_secondary,
  input wire logic       bandgap_enable,
  input wire logic       reference_io_pin_oe_n,
  input wire logic       reference_buffer_enable,
  input wire logic       range_wide,
  input wire logic       analog_power_enable,
  input wire logic       regulator_enable,
  input wire logic [1:0] interface_mode,
  input wire logic       range_settling
);
  // ----------
  // Pin history
  // ----------
  logic [4:0] h1_r, h2_r, h3_r, h4_r;
  logic [2:0] up_r;
  logic       ok;
  logic       shdn;
  // Pins reach outputs three edges late, so compare against a delayed copy
  always_ff @(posedge core_clk) begin
    h1_r <= {reference_source_select, range_select, power_down_request_n,
             interface_select_primary, interface_select_secondary};
    h2_r <= h1_r;
    h3_r <= h2_r;
    h4_r <= h3_r;
    up_r <= !reset_n ? 3'h0 : up_r + {2'h0, up_r != 3'h4};
  end
  // History is only trusted once the synchronisers have refilled
  assign ok   = up_r == 3'h4;
  assign shdn = !h3_r[2] && (h3_r[3] == SHDN_RANGE_LEVEL);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  chk_range_follow : assert property (ok |-> range_wide == h3_r[3])
    else $error("range_wide off pin level");
  chk_bandgap_sel : assert property (ok |-> bandgap_enable == (h3_r[4] && !shdn))
    else $error("bandgap_enable wrong");
  chk_ref_pin_dir : assert property (ok && !shdn |-> reference_io_pin_oe_n == !h3_r[4])
    else $error("reference pin direction wrong");
  chk_power_run : assert property (ok |-> analog_power_enable == h3_r[2])
    else $error("analog power wrong");
  chk_shdn_regs : assert property (ok |->
    regulator_enable == !shdn && reference_buffer_enable == !shdn)
    else $error("shutdown enables wrong");
  chk_iface_decode : assert property (ok |->
    interface_mode == (h3_r[1] ? (h3_r[0] ? 2'h3 : 2'h1) : 2'h0))
    else $error("interface mode wrong");
  chk_settle_start : assert property (ok && h3_r[3] != h4_r[3] |-> range_settling)
    else $error("settling not raised");
  chk_settle_hold : assert property ($rose(range_settling) |-> range_settling[*8])
    else $error("settling dropped early");
  cover property (ok && !regulator_enable);
  cover property (ok && !analog_power_enable && regulator_enable);
  cover property ($rose(range_settling));
endmodule : adc_mode_pin_control_checker
bind adc_mode_pin_control adc_mode_pin_control_checker #(.SHDN_RANGE_LEVEL(SHDN_RANGE_LEVEL))
  u_chk (.core_clk, .reset_n, .reference_source_select, .range_select, .power_down_request_n,
  .interface_select_primary, .interface_select_secondary, .bandgap_enable,
  .reference_io_pin_oe_n, .reference_buffer_enable, .range_wide, .analog_power_enable,
  .regulator_enable, .interface_mode, .range_settling);
`default_nettype wire

// ===== verification/pin_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// Host side of the pins; the bench moves levels just after a clock edge
module pin_host_model (
  input  wire logic       rst_req,
  input  wire logic [4:0] pin_cmd,
  output wire logic       reset_n,
  output wire logic       reference_source_select,
  output wire logic       range_select,
  output wire logic       power_down_request_n,
  output wire logic       interface_select_primary,
  output wire logic       interface_select_secondary
);
  // Reset after power-up and once mid-run
  assign reset_n = !rst_req;
  // Levels stay static between steps, as a tied pin would
  assign {reference_source_select, range_select, power_down_request_n,
          interface_select_primary, interface_select_secondary} = pin_cmd;
endmodule : pin_host_model
`default_nettype wire

// ===== verification/adc_mode_pin_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module adc_mode_pin_control_tb_top;
  localparam int   SETTLE = 20;
  localparam logic SHDN   = 1'b0;
  logic        core_clk, rst_req, reset_n, psel, penable, pwrite, pready, pslverr, err;
  logic        reference_source_select, range_select, power_down_request_n, shdn, bg;
  logic        interface_select_primary, interface_select_secondary, conv_result_valid;
  logic        bandgap_enable, reference_io_pin_oe_n, reference_buffer_enable, range_wide;
  logic        analog_power_enable, regulator_enable, range_settling;
  logic [1:0]  interface_mode, m;
  logic [4:0]  pin_cmd, v;
  logic [11:0] paddr;
  logic [15:0] conv_result;
  logic [31:0] pwdata, prdata, rd;
  int          failures, comparisons, cnt;

  pin_host_model u_host (.rst_req, .pin_cmd, .reset_n, .reference_source_select,
    .range_select, .power_down_request_n, .interface_select_primary,
    .interface_select_secondary);
  adc_mode_pin_control #(.SHDN_RANGE_LEVEL(SHDN), .SETTLE_CYCLES(SETTLE)) u_dut (.core_clk,
    .reset_n, .reference_source_select, .range_select, .power_down_request_n,
    .interface_select_primary, .interface_select_secondary, .conv_result, .conv_result_valid,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .bandgap_enable,
    .reference_io_pin_oe_n, .reference_buffer_enable, .range_wide, .analog_power_enable,
    .regulator_enable, .interface_mode, .range_settling);

  // 200 MHz core clock
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic give_verdict;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : give_verdict

  task automatic cycles(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cycles

  // One transfer; ready, read data and error are taken at the rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) begin
      n++;
      if (n > 20) begin
        failures++;
        give_verdict();
      end
      @(posedge core_clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Main sequence
  initial begin
    failures = 0;
    comparisons = 0;
    rst_req = 1'b1;
    pin_cmd = 5'h1C;
    {psel, penable, pwrite, conv_result_valid} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    conv_result = 16'h0;
    cycles(16);
    rst_req <= 1'b0;
    cycles(4);
    // Every pin combination: reference, range, power and interface decode
    for (int i = 0; i < 32; i++) begin
      v = i[4:0];
      @(posedge core_clk);
      pin_cmd <= v;
      cycles(5);
      shdn = !v[2] && (v[3] == SHDN);
      bg = v[4] && !shdn;
      m = !v[1] ? 2'h0 : (v[0] ? 2'h3 : 2'h1);
      apb(1'b0, 12'h004, 32'h0);
      check("status", {25'h0, m, shdn, !v[2], v[3], bg, bg}, rd & 32'h7F);
      check("power", {28'h0, !shdn, v[2], !shdn, v[3]}, {28'h0, reference_buffer_enable,
            analog_power_enable, regulator_enable, range_wide});
      apb(1'b0, 12'h00C, 32'h0);
      check("step", (v[3] ? 32'd20000000 : 32'd10000000) / 32'd65536, rd);
    end
    // Range change: host waits out the settling flag
    @(posedge core_clk);
    pin_cmd <= 5'h14;
    cnt = 0;
    for (int k = 0; k < 60; k++) begin
      @(negedge core_clk);
      if (range_settling === 1'b1) cnt++;
    end
    check("settle", 32'h1, {31'h0, cnt >= SETTLE && cnt <= SETTLE + 3});
    // Range back to wide: the status word shows the settle flag meanwhile
    @(posedge core_clk);
    pin_cmd <= 5'h1C;
    cycles(5);
    apb(1'b0, 12'h004, 32'h0);
    check("settling", 32'h1, {31'h0, rd[7]});
    // Capture path, both signs
    apb(1'b1, 12'h000, 32'h1);
    apb(1'b0, 12'h000, 32'h0);
    check("control", {30'h0, SHDN, 1'b1}, rd);
    for (int k = 0; k < 2; k++) begin
      @(posedge core_clk);
      conv_result <= k ? 16'h7FFF : 16'h8001;
      conv_result_valid <= 1'b1;
      @(posedge core_clk);
      conv_result_valid <= 1'b0;
      apb(1'b0, 12'h008, 32'h0);
      check("result", k ? 32'h0000_7FFF : 32'hFFFF_8001, rd);
    end
    // Unmapped place is refused
    apb(1'b1, 12'h010, 32'hFFFF_FFFF);
    apb(1'b0, 12'h010, 32'h0);
    check("slverr", 32'h1, {31'h0, err});
    check("unmapped", 32'h0, rd);
    // Mid-run reset wakes in the mode the select pin shows
    @(posedge core_clk);
    pin_cmd <= 5'h1C;
    rst_req <= 1'b1;
    cycles(3);
    check("oe in reset", 32'h1, {31'h0, reference_io_pin_oe_n});
    rst_req <= 1'b0;
    cycles(5);
    check("wake", 32'h2, {30'h0, bandgap_enable, reference_io_pin_oe_n});
    give_verdict();
  end
endmodule : adc_mode_pin_control_tb_top
`default_nettype wire
